// File: ntt_chain.sv
// pin-test package and the combinational gate chain behind the chain test output.
// assumes the chained pin levels arrive straight from the pads, already in
// chain order, bit 0 being the first input in the order.
package ntt_pkg;
  localparam int unsigned NTT_CHAIN_LEN = 66;
  // positions in the chain, counted from zero
  localparam int unsigned NTT_POS_PC_CARD_MODE_SEL = 0;
  localparam int unsigned NTT_POS_CABLE_NOT_ACTIVE = 1;
  localparam int unsigned NTT_POS_EEPROM_DATA = 64;
  localparam int unsigned NTT_POS_EEPROM_CLK = 65;
  // seed of the first gate, so that all-high inputs give a high output
  localparam logic NTT_CHAIN_SEED = 1'h1;
  localparam logic NTT_OUT_IDLE = 1'h0;
  localparam logic [2:0] NTT_SEL_RESET = 3'h0;

  typedef logic [NTT_CHAIN_LEN-1:0] ntt_pins_t;

  // all three selects high enter chain test mode
  function automatic logic ntt_test_mode(input logic [2:0] sel);
    ntt_test_mode = &sel;
  endfunction : ntt_test_mode
endpackage : ntt_pkg

////////////////////////////////////////////////////////////////////////////////

module ntt_chain (
  input wire ntt_pkg::ntt_pins_t chain_in,
  output logic chain_out
);
  import ntt_pkg::*;

  // a net, since every gate drives its own bit of it
  wire [NTT_CHAIN_LEN:0] link;

  // a low input forces its gate high, every later high input inverts once,
  // so pulling the inputs low in order flips the end of the chain each step
  assign link[0] = NTT_CHAIN_SEED;
  for (genvar k = 0; k < NTT_CHAIN_LEN; k++)
  begin : g_gate
    assign link[k+1] = ~(chain_in[k] & link[k]);
  end
  assign chain_out = link[NTT_CHAIN_LEN];
endmodule : ntt_chain

// File: ntt_top.sv
// pin contact test wrapper: decodes the three test selects, hands the chained
// pad levels to the gate chain and releases the pad drivers while testing.
// assumes the functional core supplies per-pad output data and enables, and
// that pad input levels are fed back unchanged to the core.

// Operation
// - chain test mode is entered only when all three test selects are high.
// - in chain test mode the chain result appears on the dedicated test output.
// - the chain path is combinational and needs no running clock.
// - with every chained input high the test output is high.
// - each next input pulled low inverts the test output.
// - sixty-six inputs are chained in fixed order, card select first, eeprom clock last.
module ntt_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic test_select_a,
  input wire logic test_select_b,
  input wire logic phy_test_select,
  input wire ntt_pkg::ntt_pins_t pad_in,
  input wire ntt_pkg::ntt_pins_t core_out,
  input wire ntt_pkg::ntt_pins_t core_oe,
  output ntt_pkg::ntt_pins_t pad_out,
  output ntt_pkg::ntt_pins_t pad_oe,
  output ntt_pkg::ntt_pins_t core_in,
  output logic chain_test_output,
  output logic test_mode_sync
);
  import ntt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic mode;
  } ntt_state_s;

  // chain-order view of the pads, last input in the top bits; a vector field
  // is a run of neighbouring inputs, lowest index first in the order
  typedef struct packed {
    logic eeprom_clk;
    logic eeprom_data;
    logic pci_clkrun_n;
    logic pci_inta_n;
    logic pci_rst_n;
    logic pci_gnt_n;
    logic pci_req_n;
    logic pci_clk;
    logic [7:0] pci_ad_31_24;
    logic pci_cbe3_n;
    logic pci_idsel;
    logic [7:0] pci_ad_23_16;
    logic pci_cbe2_n;
    logic pci_frame_n;
    logic pci_irdy_n;
    logic pci_trdy_n;
    logic pci_devsel_n;
    logic pci_stop_n;
    logic pci_perr_n;
    logic pci_serr_n;
    logic pci_par;
    logic pci_cbe1_n;
    logic [7:0] pci_ad_15_8;
    logic pci_cbe0_n;
    logic [7:0] pci_ad_7_0;
    logic bus_contender;
    logic [2:0] power_class;
    logic link_on;
    logic link_power_status;
    logic pci_active_n;
    logic chip_reset_n;
    logic scan_mode;
    logic scan_enable;
    logic aux_power_present;
    logic cable_not_active;
    logic pc_card_mode_select_n;
  } ntt_chain_pins_s;

  ntt_chain_pins_s pad_view;
  ntt_state_s state_q;
  ntt_state_s state_d;
  logic test_mode;
  logic chain_result;

  // the pads must switch without a clock, so mode is decoded straight from
  // the pins; the synchronised copy is only for clocked logic elsewhere
  assign test_mode = ntt_test_mode({test_select_a, test_select_b, phy_test_select});

  assign pad_view = pad_in;

  ntt_chain u_chain (
    .chain_in (pad_view),
    .chain_out (chain_result)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    pad_out = core_out;
    pad_oe = test_mode ? '0 : core_oe;
    core_in = pad_in;
    // a quiet low when not testing; boards hold the selects low then
    chain_test_output = test_mode ? chain_result : NTT_OUT_IDLE;
  end

  always_comb
  begin
    state_d = state_q;
    state_d.sel_meta = {test_select_a, test_select_b, phy_test_select};
    state_d.sel_sync = state_q.sel_meta;
    state_d.mode = ntt_test_mode(state_q.sel_sync);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q.sel_meta <= NTT_SEL_RESET;
      state_q.sel_sync <= NTT_SEL_RESET;
      state_q.mode <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign test_mode_sync = state_q.mode;
endmodule : ntt_top

// File: ntt_properties.sv
// port checks for ntt_top; bound from the bench top
module ntt_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic test_select_a,
  input wire logic test_select_b,
  input wire logic phy_test_select,
  input wire ntt_pkg::ntt_pins_t pad_in,
  input wire ntt_pkg::ntt_pins_t core_oe,
  input wire ntt_pkg::ntt_pins_t pad_oe,
  input wire logic chain_test_output,
  input wire logic test_mode_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  wire m = test_select_a & test_select_b & phy_test_select;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  out_off_a: assert property (!m |-> !chain_test_output) else $error("out");
  oe_off_a: assert property (m |-> pad_oe == '0) else $error("oe");
  oe_pass_a: assert property (!m |-> pad_oe == core_oe) else $error("oe");
  all_high_a: assert property (m && &pad_in |-> chain_test_output) else $error("hi");
  all_low_a: assert property (m && pad_in == '0 |-> chain_test_output) else $error("lo");
  step_flip_a: assert property (m && $past(m) && pad_in == $past(pad_in) << 1
    && |$past(pad_in) |-> chain_test_output != $past(chain_test_output)) else $error("flip");
  sync_on_a: assert property (m [*4] |-> test_mode_sync) else $error("sync");
  sync_off_a: assert property (!m [*4] |-> !test_mode_sync) else $error("sync");
  cover property (m && &pad_in);
  cover property (m && pad_in == '0);
  cover property (test_mode_sync);
endmodule : ntt_props

// File: ntt_tester.sv
// board tester model: pulls the chained pads low from bit 0 upward
module ntt_tester (
  input wire logic [6:0] lows,
  output ntt_pkg::ntt_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pins = '1 << lows;
endmodule : ntt_tester

// File: nand_tree_pin_test_tb_top.sv
// bench for ntt_top; inputs change on falling edges, 25 MHz clock
// assumes the tester model sets the chained pads; the checker is bound below
module nand_tree_pin_test_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
  logic clk = 0, srst = 1, test_select_a = 0, test_select_b = 0, phy_test_select = 0;
  logic [6:0] lows = 0;
  ntt_pkg::ntt_pins_t pad_in, core_out = '0, core_oe = '0, pad_out, pad_oe, core_in;
  logic chain_test_output, test_mode_sync;
  int fails = 0, checks = 0, cyc = 0;
  ntt_tester TST (.lows(lows), .pins(pad_in));
  ntt_top DUT (
    .clk(clk),
    .srst(srst),
    .test_select_a(test_select_a),
    .test_select_b(test_select_b),
    .phy_test_select(phy_test_select),
    .pad_in(pad_in),
    .core_out(core_out),
    .core_oe(core_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .core_in(core_in),
    .chain_test_output(chain_test_output),
    .test_mode_sync(test_mode_sync)
  );
  initial forever #20 clk = ~clk;
  // the whole run needs under a hundred cycles; a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic t_normal();
    for (int s = 0; s < 7; s++)
    begin
      @(negedge clk) {test_select_a, test_select_b, phy_test_select} = s[2:0];
      core_oe = {33{s[1:0]}};
      core_out = ~core_oe;
      #1 `CHK(chain_test_output, 1'h0)
      `CHK(pad_oe, core_oe)
      `CHK(pad_out, core_out)
      `CHK(core_in, pad_in)
    end
    `CHK(test_mode_sync, 1'h0)
    $display("normal done");
  endtask : t_normal
  task automatic t_walk();
    @(negedge clk) {test_select_a, test_select_b, phy_test_select} = 3'h7;
    core_oe = '1;
    core_out = '1;
    for (int k = 0; k <= 66; k++)
    begin
      @(negedge clk) lows = k[6:0];
      #1 `CHK(chain_test_output, ~k[0])
      `CHK(pad_oe, 66'h0)
      `CHK(core_in, pad_in)
      `CHK(pad_out, core_out)
    end
    `CHK(test_mode_sync, 1'h1)
    @(negedge clk) {test_select_a, test_select_b, phy_test_select} = 3'h0;
    #1 `CHK(pad_oe, core_oe)
    `CHK(chain_test_output, 1'h0)
    $display("walk done");
  endtask : t_walk
  initial
  begin
    repeat (8) @(negedge clk);
    srst = 0;
    t_normal();
    t_walk();
    print_verdict();
  end
endmodule : nand_tree_pin_test_tb_top
bind ntt_top ntt_props PROPS (
  .clk(clk),
  .srst(srst),
  .test_select_a(test_select_a),
  .test_select_b(test_select_b),
  .phy_test_select(phy_test_select),
  .pad_in(pad_in),
  .core_oe(core_oe),
  .pad_oe(pad_oe),
  .chain_test_output(chain_test_output),
  .test_mode_sync(test_mode_sync)
);
